//--- src/itr_pkg.sv
/*
  Shared constants and types for the I2C register-access target and its bus controller.
  Assumes a 50 MHz system clock and an open-drain bus resolved in the carrier interface.
*/
package itr_pkg;
  localparam logic [6:0] OWN_ADDR_DFLT = 7'h25;
  localparam logic [7:0] REG_FIRST = 8'h00;
  localparam logic [7:0] REG_LAST = 8'h69;
  localparam logic [7:0] RD_FILL = 8'hFF;
  localparam int REG_COUNT = 106;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam int MCLK_PERIOD_NS = 20;
  localparam int SCL_RATE_KBPS = 1000;
  localparam int SCL_HALF_NS = 1000000 / (2 * SCL_RATE_KBPS);
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_PTR = 3'b010,
    PH_WDATA = 3'b011,
    PH_RDATA = 3'b100
  } itr_phase_t;

  typedef enum logic [1:0] {
    CMD_START = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_READ = 2'b10,
    CMD_STOP = 2'b11
  } itr_cmd_t;

  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_START = 2'b01,
    CS_BIT = 2'b10,
    CS_STOP = 2'b11
  } itr_cstate_t;
endpackage : itr_pkg

//--- src/itr_if.sv
/*
  Two-wire bus carrier joining target and controller.
  Assumes both ends drive only output enables; the wired-AND level is resolved here.
*/
`timescale 1ns/100ps
interface itr_if;
  logic scl_dev_oe;
  logic sda_dev_oe;
  logic scl_ctl_oe;
  logic sda_ctl_oe;
  logic scl;
  logic sda;

  assign scl = ~(scl_dev_oe | scl_ctl_oe);
  assign sda = ~(sda_dev_oe | sda_ctl_oe);

  modport dev (input scl, input sda, output scl_dev_oe, output sda_dev_oe);
  modport ctl (input scl, input sda, output scl_ctl_oe, output sda_ctl_oe);
endinterface : itr_if

//--- src/itr_target.sv
/*
  I2C target giving register access to an array of 8-bit configuration registers.
  Assumes SCL is the link clock for the bit engine, mclk runs the register array, and
  own_addr is static while the bus is busy.
*/
`timescale 1ns/100ps
module itr_target
  import itr_pkg::*;
(
  // System
  input wire logic mclk,
  input wire logic rst_b,
  // Bus pins
  itr_if.dev bus,
  // Configuration
  input wire logic [6:0] own_addr,
  // Register side
  output logic bus_busy,
  output logic wr_stb,
  output logic [7:0] wr_idx,
  output logic [7:0] wr_data
);

  logic link_rst_q;
  logic sta_q;
  logic sta_ack_q;
  logic sta_ack_d;
  logic sta_clr;
  logic sto_q;

  itr_phase_t phase_q;
  itr_phase_t phase_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic [7:0] wptr_q;
  logic [7:0] wptr_d;
  logic [7:0] wdat_q;
  logic [7:0] wdat_d;
  logic wr_tgl_q;
  logic wr_tgl_d;
  logic rd_tgl_q;
  logic rd_tgl_d;
  logic [7:0] rx_byte;
  logic addr_hit;

  logic ack_oe_q;
  logic ack_oe_d;
  logic tx_on_q;
  logic tx_on_d;
  logic [2:0] txsel_q;
  logic [2:0] txsel_d;

  logic [1:0] scl_s_q;
  logic [1:0] rd_s_q;
  logic [1:0] wr_s_q;
  logic [1:0] sto_s_q;
  logic [1:0] scl_s_d;
  logic [1:0] rd_s_d;
  logic [1:0] wr_s_d;
  logic [1:0] sto_s_d;
  logic rd_seen_q;
  logic rd_seen_d;
  logic wr_seen_q;
  logic wr_seen_d;
  logic stretch_q;
  logic stretch_d;
  logic [7:0] rd_q;
  logic [7:0] rd_d;
  logic wr_stb_q;
  logic wr_stb_d;
  logic [7:0] wr_idx_q;
  logic [7:0] wr_idx_d;
  logic [7:0] wr_data_q;
  logic [7:0] wr_data_d;
  logic mem_we;
  logic [7:0] mem [REG_COUNT];

  // The link flops are cleared from a registered copy of reset, since SCL may be still.
  always_ff @(posedge mclk) begin
    link_rst_q <= ~rst_b;
  end

  assign sta_clr = link_rst_q | sta_ack_q;

  always_ff @(negedge bus.sda or posedge sta_clr) begin
    if (sta_clr) begin
      sta_q <= 1'b0;
    end else if (bus.scl) begin
      sta_q <= 1'b1;
    end
  end

  always_ff @(posedge bus.sda or posedge link_rst_q or posedge sta_q) begin
    if (link_rst_q) begin
      sto_q <= 1'b1;
    end else if (sta_q) begin
      sto_q <= 1'b0;
    end else if (bus.scl) begin
      sto_q <= 1'b1;
    end
  end

  assign rx_byte = {shift_q[6:0], bus.sda};
  assign addr_hit = (shift_q[7:1] == own_addr);

  always_comb begin
    sta_ack_d = sta_q;
    phase_d = phase_q;
    bit_d = bit_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    wptr_d = wptr_q;
    wdat_d = wdat_q;
    wr_tgl_d = wr_tgl_q;
    rd_tgl_d = rd_tgl_q;
    if (sta_q) begin
      phase_d = PH_ADDR;
      bit_d = 4'h1;
      shift_d = {7'h00, bus.sda};
    end else if (phase_q == PH_IDLE) begin
      bit_d = 4'h0;
    end else if (bit_q != ACK_BIT) begin
      shift_d = rx_byte;
      bit_d = bit_q + 4'h1;
    end else begin
      bit_d = 4'h0;
      unique case (phase_q)
        PH_ADDR: begin
          if (!addr_hit) begin
            phase_d = PH_IDLE;
          end else if (shift_q[0]) begin
            phase_d = PH_RDATA;
            rd_tgl_d = ~rd_tgl_q;
          end else begin
            phase_d = PH_PTR;
          end
        end
        PH_PTR: begin
          ptr_d = shift_q;
          phase_d = PH_WDATA;
        end
        PH_WDATA: begin
          wptr_d = ptr_q;
          wdat_d = shift_q;
          wr_tgl_d = ~wr_tgl_q;
          ptr_d = ptr_q + 8'h01;
        end
        PH_RDATA: begin
          if (!bus.sda) begin
            ptr_d = ptr_q + 8'h01;
            rd_tgl_d = ~rd_tgl_q;
          end else begin
            phase_d = PH_IDLE;
          end
        end
        default: begin
          phase_d = PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge bus.scl or posedge link_rst_q) begin
    if (link_rst_q) begin
      sta_ack_q <= 1'b0;
      phase_q <= PH_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= REG_FIRST;
      wptr_q <= REG_FIRST;
      wdat_q <= 8'h00;
      wr_tgl_q <= 1'b0;
      rd_tgl_q <= 1'b0;
    end else begin
      sta_ack_q <= sta_ack_d;
      phase_q <= phase_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      wptr_q <= wptr_d;
      wdat_q <= wdat_d;
      wr_tgl_q <= wr_tgl_d;
      rd_tgl_q <= rd_tgl_d;
    end
  end

  always_comb begin
    ack_oe_d = 1'b0;
    tx_on_d = 1'b0;
    txsel_d = bit_q[2:0];
    if (!sta_q && bit_q == ACK_BIT) begin
      unique case (phase_q)
        PH_ADDR: ack_oe_d = addr_hit;
        PH_PTR, PH_WDATA: ack_oe_d = 1'b1;
        default: ack_oe_d = 1'b0;
      endcase
    end
    if (!sta_q && phase_q == PH_RDATA && bit_q != ACK_BIT) begin
      tx_on_d = 1'b1;
    end
  end

  always_ff @(negedge bus.scl or posedge link_rst_q) begin
    if (link_rst_q) begin
      ack_oe_q <= 1'b0;
      tx_on_q <= 1'b0;
      txsel_q <= 3'h0;
    end else begin
      ack_oe_q <= ack_oe_d;
      tx_on_q <= tx_on_d;
      txsel_q <= txsel_d;
    end
  end

  assign bus.sda_dev_oe = ~sto_q & (ack_oe_q | (tx_on_q & ~rd_q[~txsel_q]));
  assign bus.scl_dev_oe = stretch_q;

  always_comb begin
    scl_s_d = {scl_s_q[0], bus.scl};
    rd_s_d = {rd_s_q[0], rd_tgl_q};
    wr_s_d = {wr_s_q[0], wr_tgl_q};
    sto_s_d = {sto_s_q[0], sto_q};
    rd_seen_d = rd_seen_q;
    wr_seen_d = wr_seen_q;
    stretch_d = 1'b0;
    rd_d = rd_q;
    wr_stb_d = 1'b0;
    wr_idx_d = wr_idx_q;
    wr_data_d = wr_data_q;
    mem_we = 1'b0;
    if (rd_s_q[1] != rd_seen_q && !scl_s_q[1]) begin
      stretch_d = 1'b1;
      rd_seen_d = rd_s_q[1];
      rd_d = (ptr_q <= REG_LAST) ? mem[ptr_q[6:0]] : RD_FILL;
    end
    if (wr_s_q[1] != wr_seen_q) begin
      wr_seen_d = wr_s_q[1];
      if (wptr_q <= REG_LAST) begin
        mem_we = 1'b1;
        wr_stb_d = 1'b1;
        wr_idx_d = wptr_q;
        wr_data_d = wdat_q;
      end
    end
  end

  // The pointer and write words cross as held values announced by toggles.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      scl_s_q <= 2'h3;
      rd_s_q <= 2'h0;
      wr_s_q <= 2'h0;
      sto_s_q <= 2'h3;
      rd_seen_q <= 1'b0;
      wr_seen_q <= 1'b0;
      stretch_q <= 1'b0;
      rd_q <= 8'h00;
      wr_stb_q <= 1'b0;
      wr_idx_q <= 8'h00;
      wr_data_q <= 8'h00;
      for (int i = 0; i < REG_COUNT; i++) begin
        mem[i] <= 8'h00;
      end
    end else begin
      scl_s_q <= scl_s_d;
      rd_s_q <= rd_s_d;
      wr_s_q <= wr_s_d;
      sto_s_q <= sto_s_d;
      rd_seen_q <= rd_seen_d;
      wr_seen_q <= wr_seen_d;
      stretch_q <= stretch_d;
      rd_q <= rd_d;
      wr_stb_q <= wr_stb_d;
      wr_idx_q <= wr_idx_d;
      wr_data_q <= wr_data_d;
      if (mem_we) begin
        mem[wptr_q[6:0]] <= wdat_q;
      end
    end
  end

  assign bus_busy = ~sto_s_q[1];
  assign wr_stb = wr_stb_q;
  assign wr_idx = wr_idx_q;
  assign wr_data = wr_data_q;

endmodule : itr_target

//--- src/itr_ctl.sv
/*
  I2C bus controller issuing start, byte write, byte read and stop on command.
  Assumes the target end shares the carrier interface and may stretch SCL.
*/
`timescale 1ns/100ps
module itr_ctl
  import itr_pkg::*;
#(
  parameter int HALF_CYC = SCL_HALF_CYC
) (
  // System
  input wire logic mclk,
  input wire logic rst_b,
  // Bus pins
  itr_if.ctl bus,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire itr_cmd_t cmd_op,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_nack,
  // Response
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_nack
);

  localparam logic [15:0] TMR_END = 16'(HALF_CYC - 1);

  itr_cstate_t cs_q;
  itr_cstate_t cs_d;
  logic [1:0] step_q;
  logic [1:0] step_d;
  logic [15:0] tmr_q;
  logic [15:0] tmr_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [8:0] txb_q;
  logic [8:0] txb_d;
  logic [8:0] rxb_q;
  logic [8:0] rxb_d;
  logic scl_oe_q;
  logic scl_oe_d;
  logic sda_oe_q;
  logic sda_oe_d;
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic rsp_valid_q;
  logic rsp_valid_d;
  logic [7:0] rsp_rdata_q;
  logic [7:0] rsp_rdata_d;
  logic rsp_nack_q;
  logic rsp_nack_d;
  logic done;

  assign done = (tmr_q == TMR_END) && (scl_oe_q || scl_s_q[1]);

  always_comb begin
    cs_d = cs_q;
    step_d = step_q;
    tmr_d = (scl_oe_q || scl_s_q[1]) ? tmr_q + 16'h0001 : tmr_q;
    bit_d = bit_q;
    txb_d = txb_q;
    rxb_d = rxb_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    rsp_valid_d = 1'b0;
    rsp_rdata_d = rsp_rdata_q;
    rsp_nack_d = rsp_nack_q;
    if (done) begin
      tmr_d = 16'h0000;
      step_d = step_q + 2'h1;
    end
    unique case (cs_q)
      CS_IDLE: begin
        tmr_d = 16'h0000;
        step_d = 2'h0;
        bit_d = 4'h0;
        if (cmd_valid) begin
          unique case (cmd_op)
            CMD_START: begin
              cs_d = CS_START;
              sda_oe_d = 1'b0;
            end
            CMD_WRITE: begin
              cs_d = CS_BIT;
              txb_d = {cmd_wdata, 1'b1};
              sda_oe_d = ~cmd_wdata[7];
            end
            CMD_READ: begin
              cs_d = CS_BIT;
              txb_d = {8'hFF, cmd_nack};
              sda_oe_d = 1'b0;
            end
            CMD_STOP: begin
              cs_d = CS_STOP;
              sda_oe_d = 1'b1;
            end
          endcase
        end
      end
      CS_START: begin
        if (done) begin
          unique case (step_q)
            2'h0: scl_oe_d = 1'b0;
            2'h1: sda_oe_d = 1'b1;
            2'h2: scl_oe_d = 1'b1;
            2'h3: cs_d = CS_IDLE;
          endcase
        end
      end
      CS_BIT: begin
        if (done) begin
          if (step_q == 2'h0) begin
            scl_oe_d = 1'b0;
          end else begin
            rxb_d = {rxb_q[7:0], sda_s_q[1]};
            scl_oe_d = 1'b1;
            step_d = 2'h0;
            if (bit_q == ACK_BIT) begin
              cs_d = CS_IDLE;
              rsp_valid_d = 1'b1;
              rsp_rdata_d = rxb_q[7:0];
              rsp_nack_d = sda_s_q[1];
            end else begin
              bit_d = bit_q + 4'h1;
              sda_oe_d = ~txb_q[7];
              txb_d = {txb_q[7:0], 1'b1};
            end
          end
        end
      end
      CS_STOP: begin
        if (done) begin
          unique case (step_q)
            2'h0: scl_oe_d = 1'b0;
            2'h1: sda_oe_d = 1'b0;
            default: cs_d = CS_IDLE;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cs_q <= CS_IDLE;
      step_q <= 2'h0;
      tmr_q <= 16'h0000;
      bit_q <= 4'h0;
      txb_q <= 9'h1FF;
      rxb_q <= 9'h000;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 8'h00;
      rsp_nack_q <= 1'b0;
    end else begin
      cs_q <= cs_d;
      step_q <= step_d;
      tmr_q <= tmr_d;
      bit_q <= bit_d;
      txb_q <= txb_d;
      rxb_q <= rxb_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      scl_s_q <= {scl_s_q[0], bus.scl};
      sda_s_q <= {sda_s_q[0], bus.sda};
      rsp_valid_q <= rsp_valid_d;
      rsp_rdata_q <= rsp_rdata_d;
      rsp_nack_q <= rsp_nack_d;
    end
  end

  assign cmd_ready = (cs_q == CS_IDLE);
  assign bus.scl_ctl_oe = scl_oe_q;
  assign bus.sda_ctl_oe = sda_oe_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign rsp_nack = rsp_nack_q;

endmodule : itr_ctl

//--- bench/itr_asserts.sv
/*
  Concurrent checks on the two-wire carrier and the target's status outputs.
  Assumes it sits beside the carrier, sampling all lines on the system clock.
*/
`timescale 1ns/100ps
module itr_asserts (
  // System
  input wire logic mclk,
  input wire logic rst_b,
  // Carrier
  input wire logic scl_dev_oe,
  input wire logic sda_dev_oe,
  input wire logic scl_ctl_oe,
  input wire logic sda_ctl_oe,
  input wire logic scl,
  input wire logic sda,
  // Target status
  input wire logic bus_busy,
  input wire logic wr_stb
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  property p_dev_sda_edge;
    $rose(sda_dev_oe) |-> !scl;
  endproperty
  a_dev_sda_edge: assert property (p_dev_sda_edge)
    else $error("target pulled SDA while SCL high");
  property p_stretch_low;
    $rose(scl_dev_oe) |-> $past(!scl);
  endproperty
  a_stretch_low: assert property (p_stretch_low)
    else $error("target stretched an SCL that was high");
  property p_stretch_pulse;
    scl_dev_oe |=> !scl_dev_oe;
  endproperty
  a_stretch_pulse: assert property (p_stretch_pulse)
    else $error("SCL stretch longer than one cycle");
  property p_scl_fall;
    $fell(scl) |-> scl_ctl_oe;
  endproperty
  a_scl_fall: assert property (p_scl_fall)
    else $error("SCL fell without the controller");
  property p_start_ctl;
    $fell(sda) && scl |-> sda_ctl_oe;
  endproperty
  a_start_ctl: assert property (p_start_ctl)
    else $error("start made by the target");
  // Busy comes through a two-flop crossing, so a few cycles of lag are allowed.
  property p_start_busy;
    scl && $past(scl) && $fell(sda) |-> ##[1:6] bus_busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy not raised after start");
  property p_stop_idle;
    scl && $past(scl) && $rose(sda) |-> ##[1:6] !bus_busy;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("busy not cleared after stop");
  property p_dev_busy;
    sda_dev_oe |-> bus_busy;
  endproperty
  a_dev_busy: assert property (p_dev_busy)
    else $error("target drove SDA on a free bus");
  property p_wr_pulse;
    wr_stb |-> bus_busy ##1 !wr_stb;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe malformed");
endmodule : itr_asserts

//--- bench/i2c_target_register_access_test.sv
/*
  Self-checking bench: controller and target joined on one carrier, driven by commands.
  Assumes a 50 MHz mclk and the carrier resolving the open-drain lines.
*/
`timescale 1ns/100ps
module i2c_target_register_access_test
  import itr_pkg::*;
;
  // Six cycles a half bit keeps the run short yet leaves the target its read fetch time.
  localparam int HALF = 6;
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] data;
    logic [7:0] exp;
  } itr_row_t;
  logic mclk;
  logic rst_b;
  logic [6:0] own_addr;
  logic bus_busy;
  logic wr_stb;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic cmd_valid;
  logic cmd_ready;
  itr_cmd_t cmd_op;
  logic [7:0] cmd_wdata;
  logic cmd_nack;
  logic rsp_valid;
  logic [7:0] rsp_rdata;
  logic rsp_nack;
  int num_errors;
  int checks;
  logic [7:0] mem [256];
  logic [15:0] wq [$];
  itr_row_t rows [4];

  itr_if bus ();
  itr_target itr_target_inst (.mclk(mclk), .rst_b(rst_b), .bus(bus), .own_addr(own_addr),
    .bus_busy(bus_busy), .wr_stb(wr_stb), .wr_idx(wr_idx), .wr_data(wr_data));
  itr_ctl #(.HALF_CYC(HALF)) itr_ctl_inst (.mclk(mclk), .rst_b(rst_b), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_wdata(cmd_wdata),
    .cmd_nack(cmd_nack), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
  itr_asserts itr_asserts_inst (.mclk(mclk), .rst_b(rst_b), .scl_dev_oe(bus.scl_dev_oe),
    .sda_dev_oe(bus.sda_dev_oe), .scl_ctl_oe(bus.scl_ctl_oe), .sda_ctl_oe(bus.sda_ctl_oe),
    .scl(bus.scl), .sda(bus.sda), .bus_busy(bus_busy), .wr_stb(wr_stb));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // The strobe stands a whole cycle, so sampling mid-cycle avoids edge races.
  always @(negedge mclk) begin
    if (wr_stb === 1'b1) begin
      wq.push_back({wr_idx, wr_data});
    end
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset();
    rst_b = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
  endtask : do_reset

  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 3000) begin
        num_errors++;
        give_verdict();
      end
    end
  endtask : wait_ready

  task automatic xfer(input itr_cmd_t op, input logic [7:0] d, input logic nk);
    wait_ready();
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_wdata = d;
    cmd_nack = nk;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    wait_ready();
    chk({15'h0000, rsp_valid}, {15'h0000, op == CMD_WRITE || op == CMD_READ});
  endtask : xfer

  task automatic wb(input logic [7:0] d, input logic nk);
    xfer(CMD_WRITE, d, 1'b0);
    chk({15'h0000, rsp_nack}, {15'h0000, nk});
  endtask : wb

  task automatic setptr(input logic [7:0] p);
    xfer(CMD_START, 8'h00, 1'b0);
    wb({own_addr, 1'b0}, 1'b0);
    chk({15'h0000, bus_busy}, 16'h0001);
    wb(p, 1'b0);
  endtask : setptr

  task automatic wr_burst(input logic [7:0] p, input int n, input logic [7:0] b);
    logic [7:0] a;
    setptr(p);
    for (int i = 0; i < n; i++) begin
      wb(b + i[7:0], 1'b0);
    end
    xfer(CMD_STOP, 8'h00, 1'b0);
    for (int i = 0; i < n; i++) begin
      a = p + i[7:0];
      if (a <= REG_LAST) begin
        mem[a] = b + i[7:0];
        chk((wq.size() != 0) ? wq.pop_front() : 16'hXXXX, {a, mem[a]});
      end
    end
    chk({15'h0000, wq.size() != 0}, 16'h0000);
  endtask : wr_burst

  task automatic rd_burst(input logic [7:0] p, input int n);
    logic [7:0] a;
    logic [7:0] e;
    setptr(p);
    xfer(CMD_START, 8'h00, 1'b0);
    wb({own_addr, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) begin
      a = p + i[7:0];
      e = (a <= REG_LAST) ? mem[a] : RD_FILL;
      xfer(CMD_READ, 8'h00, i == n - 1);
      chk({rsp_nack, 7'h00, rsp_rdata}, {i == n - 1, 7'h00, e});
    end
    xfer(CMD_STOP, 8'h00, 1'b0);
  endtask : rd_burst

  // Roughly six times the expected run length.
  initial begin
    #1200000;
    num_errors++;
    give_verdict();
  end

  initial begin
    rst_b = 1'b0;
    own_addr = OWN_ADDR_DFLT;
    cmd_valid = 1'b0;
    cmd_op = CMD_START;
    cmd_wdata = 8'h00;
    cmd_nack = 1'b0;
    rows = '{'{8'h00, 8'hA5, 8'hA5}, '{8'h69, 8'h3C, 8'h3C}, '{8'h6A, 8'h77, 8'hFF},
      '{8'h35, 8'h5A, 8'h5A}};
    do_reset();
    chk({14'h0000, bus_busy, cmd_ready}, 16'h0001);
    chk({14'h0000, bus.scl, bus.sda}, 16'h0003);
    rd_burst(8'h10, 1);
    foreach (rows[i]) begin
      wr_burst(rows[i].ptr, 1, rows[i].data);
      rd_burst(rows[i].ptr, 1);
      chk({8'h00, rsp_rdata}, {8'h00, rows[i].exp});
    end
    // Burst across the last register; the byte past it is taken but dropped.
    wr_burst(8'h67, 4, 8'hC0);
    rd_burst(8'h66, 5);
    // Pointer wraps from the top of the space back to the first register.
    rd_burst(8'hFF, 2);
    // Foreign address: no acknowledge, and the next byte is ignored.
    xfer(CMD_START, 8'h00, 1'b0);
    wb({OWN_ADDR_DFLT + 7'h01, 1'b0}, 1'b1);
    wb(8'h11, 1'b1);
    xfer(CMD_STOP, 8'h00, 1'b0);
    repeat (6) @(posedge mclk);
    #1;
    chk({15'h0000, bus_busy}, 16'h0000);
    chk({15'h0000, wq.size() != 0}, 16'h0000);
    // A moved own address: the old one goes unanswered and the new one works.
    own_addr = 7'h3A;
    xfer(CMD_START, 8'h00, 1'b0);
    wb({OWN_ADDR_DFLT, 1'b0}, 1'b1);
    xfer(CMD_STOP, 8'h00, 1'b0);
    wr_burst(8'h20, 1, 8'h96);
    rd_burst(8'h20, 1);
    chk({8'h00, rsp_rdata}, 16'h0096);
    own_addr = OWN_ADDR_DFLT;
    // Reset in mid-transfer must free the bus and clear the registers.
    xfer(CMD_START, 8'h00, 1'b0);
    wb({OWN_ADDR_DFLT, 1'b0}, 1'b0);
    do_reset();
    chk({14'h0000, bus.scl, bus.sda}, 16'h0003);
    rd_burst(8'h00, 1);
    give_verdict();
  end
endmodule : i2c_target_register_access_test
